//--- verilog/pfail_top.sv
`timescale 1ns/10ps
module pfail_top
   import pfail_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES  = HOLD_CYC,
   parameter int unsigned DELAY_CYCLES = DELAY_DEF_CYC
)
(
   input  wire logic               CLK,
   input  wire logic               RST,
   input  wire logic               CE,
   input  wire logic [NUM_MON-1:0] SUPPLY_OK,
   input  wire logic [NUM_MON-1:0] LINE_TICK,
   input  wire logic [NUM_MON-1:0] POWER_ON_GATE,
   input  wire logic               OTHER_REQ,
   input  wire logic [7:0]         OTHER_VEC,
   output logic                    MASTER_RESET_LEVEL,
   output logic                    POWER_ON_PULSE,
   output logic                    POWER_OFF_PULSE,
   output logic                    LINE_TICK_OUT,
   output logic                    PWR_ON_REQ,
   output logic                    PWR_OFF_REQ,
   output logic                    IRQ_ANY,
   output logic [7:0]              IRQ_VEC
);
   import pfail_pkg::*;

   // One counter serves the hold time and the shutdown delay, never both at once
   typedef enum logic [1:0] {PH_HOLD, PH_RUN, PH_FAIL} pfail_state_e;

   // Count ends are inclusive, so each wait lasts its full cycle count

   localparam logic [CNT_W-1:0] HOLD_LAST  = CNT_W'(HOLD_CYCLES - 1);
   localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(DELAY_CYCLES - 1);

   // One instance per monitor would be the board wiring; here the fail and
   // tick groups of like-named monitor outputs are each merged by one OR
   logic fail_any;
   logic gate_all;
   logic tick_any;
   logic [NUM_MON-1:0] fail_vec;

   genvar g;
   generate
      for (g = 0; g < NUM_MON; g++)
      begin : g_mon
         assign fail_vec[g] = ~SUPPLY_OK[g];
      end
   endgenerate

   pfail_or u_or_fail
   (
      .mon_in (fail_vec),
      .or_out (fail_any)
   );
   pfail_or u_or_tick
   (
      .mon_in (LINE_TICK),
      .or_out (tick_any)
   );
   // Gate is an AND: every monitor must enable power-on
   assign gate_all = &POWER_ON_GATE;

   pfail_state_e     state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic             fail_d_ff;

   // Monitor levels are taken as synchronous to CLK, so no synchroniser stages
   // Previous fail level, so the shutdown pulse marks only the first cycle of a fail

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         fail_d_ff <= 1'b0;
      else if (CE)
         fail_d_ff <= fail_any;
   end

   // Startup / shutdown sequencing of the master reset level
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state_ff <= PH_HOLD;
         cnt_ff   <= '0;
      end
      else if (CE)
      begin
         unique case (state_ff)
            PH_HOLD:
            begin
               // Any supply fail restarts the whole hold period and keeps it at zero while the fail lasts
               if (fail_any)
                  cnt_ff <= '0;
               else if (cnt_ff == HOLD_LAST)
               begin
                  // Gate low parks here with the reset level still held
                  if (gate_all)
                     state_ff <= PH_RUN;
               end
               else
                  cnt_ff <= cnt_ff + 1'b1;
            end
            PH_RUN:
            begin
               if (fail_any)
               begin
                  state_ff <= PH_FAIL;
                  cnt_ff   <= '0;
               end
            end
            PH_FAIL:
            begin
               // Supplies still in regulation during the delay; a fail
               // seen here is left for the hold phase to catch
               if (cnt_ff == DELAY_LAST)
               begin
                  state_ff <= PH_HOLD;
                  cnt_ff   <= '0;
               end
               else
                  cnt_ff <= cnt_ff + 1'b1;
            end
            // Spare code of the two-bit state falls back to a fresh hold
            default:
            begin
               state_ff <= PH_HOLD;
               cnt_ff   <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         MASTER_RESET_LEVEL <= MRST_RST;
      else if (CE)
         // Reset level drops on the edge that sends the start pulse,
         // so the processor leaves reset already owning the request
         MASTER_RESET_LEVEL <= (state_ff == PH_HOLD) &&
                               !(cnt_ff == HOLD_LAST && gate_all && !fail_any);
   end

   // Start and shutdown pulses, one cycle each
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         POWER_ON_PULSE  <= 1'b0;
         POWER_OFF_PULSE <= 1'b0;
      end
      else if (CE)
      begin
         POWER_ON_PULSE  <= state_ff == PH_HOLD && cnt_ff == HOLD_LAST &&
                            gate_all && !fail_any;
         POWER_OFF_PULSE <= fail_any && !fail_d_ff;
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         LINE_TICK_OUT <= 1'b0;
      else if (CE)
         // Passed through only; the sequencing never reads the tick
         LINE_TICK_OUT <= tick_any;
   end

   // Request levels have no enable or mask input at all, so software cannot touch them
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         PWR_ON_REQ  <= 1'b0;
         PWR_OFF_REQ <= 1'b0;
      end
      else if (CE)
      begin
         PWR_ON_REQ  <= state_ff == PH_HOLD && cnt_ff == HOLD_LAST &&
                        gate_all && !fail_any;
         PWR_OFF_REQ <= fail_any && !fail_d_ff && state_ff == PH_RUN;
      end
   end

   // Fixed priority: power-on, then power-off, then the rest
   // Other requests win only in cycles where neither power level is up
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         IRQ_ANY <= 1'b0;
         IRQ_VEC <= VEC_NONE;
      end
      else if (CE)
      begin
         IRQ_ANY <= PWR_ON_REQ | PWR_OFF_REQ | OTHER_REQ;
         if (PWR_ON_REQ)
            IRQ_VEC <= VEC_POWER_ON;
         else if (PWR_OFF_REQ)
            IRQ_VEC <= VEC_POWER_OFF;
         else if (OTHER_REQ)
            IRQ_VEC <= OTHER_VEC;
         else
            IRQ_VEC <= VEC_NONE;
      end
   end
endmodule

//--- verilog/pfail_pkg.sv
package pfail_pkg;
   // Clock rate
   localparam int unsigned CLK_HZ        = 100_000_000;
   // Master reset hold after power application, least time
   localparam int unsigned HOLD_MS       = 300;
   localparam int unsigned HOLD_CYC      = (HOLD_MS * (CLK_HZ / 1000));
   // Shutdown delay period, adjustable 5 to 20 ms, default setting 10 ms
   localparam int unsigned DELAY_MIN_MS  = 5;
   localparam int unsigned DELAY_MAX_MS  = 20;
   localparam int unsigned DELAY_DEF_MS  = 10;
   localparam int unsigned DELAY_DEF_CYC = (DELAY_DEF_MS * (CLK_HZ / 1000));
   localparam int unsigned CNT_W         = 25;
   // Fixed interrupt memory locations
   localparam logic [7:0]  VEC_POWER_ON  = 8'h50;
   localparam logic [7:0]  VEC_POWER_OFF = 8'h51;
   localparam logic [7:0]  VEC_NONE      = 8'h00;
   // Number of wired-OR monitors
   localparam int unsigned NUM_MON       = 2;
   // Reset values
   localparam logic        MRST_RST      = 1'b1;
endpackage

//--- verilog/pfail_or.sv
`timescale 1ns/10ps
// Wired-OR of like-named outputs from several monitors
module pfail_or
   import pfail_pkg::*;
(
   input  wire logic [NUM_MON-1:0] mon_in,
   output wire logic               or_out
);
   assign or_out = |mon_in;
endmodule

//--- tb/pfail_cpu.sv
`timescale 1ns/10ps
module pfail_cpu
(
   input logic  clk,
   input logic  rst,
   input logic  on_req,
   input logic  off_req,
   input logic  ack_on,
   input logic  ack_off,
   output logic pend_on,
   output logic pend_off
);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pend_on  <= 1'b0;
         pend_off <= 1'b0;
      end
      else
      begin
         // Ack clears only its own level
         pend_on  <= on_req | (pend_on & ~ack_on);
         pend_off <= off_req | (pend_off & ~ack_off);
      end
   end
endmodule

//--- tb/pfail_props.sv
`timescale 1ns/10ps
module pfail_props
   import pfail_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES  = 20,
   parameter int unsigned DELAY_CYCLES = 5
)
(
   input logic               CLK,
   input logic               RST,
   input logic [NUM_MON-1:0] SUPPLY_OK,
   input logic [NUM_MON-1:0] LINE_TICK,
   input logic [NUM_MON-1:0] POWER_ON_GATE,
   input logic               MASTER_RESET_LEVEL,
   input logic               POWER_ON_PULSE,
   input logic               PWR_ON_REQ,
   input logic               PWR_OFF_REQ,
   input logic               POWER_OFF_PULSE,
   input logic               LINE_TICK_OUT,
   input logic               IRQ_ANY,
   input logic [7:0]         IRQ_VEC
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_on_vector: assert property (PWR_ON_REQ |=> IRQ_VEC == 8'h50 && IRQ_ANY)
      else $error("on vector");
   a_off_vector: assert property (PWR_OFF_REQ && !PWR_ON_REQ |=> IRQ_VEC == 8'h51)
      else $error("off vector");
   a_on_release: assert property (PWR_ON_REQ |-> POWER_ON_PULSE && $fell(MASTER_RESET_LEVEL))
      else $error("on release");
   a_release_cause: assert property ($fell(MASTER_RESET_LEVEL) |->
      &$past(SUPPLY_OK) && &$past(POWER_ON_GATE))
      else $error("release cause");
   a_hold_min: assert property ($fell(MASTER_RESET_LEVEL) |-> $past(MASTER_RESET_LEVEL, HOLD_CYCLES))
      else $error("hold short");
   a_off_edge: assert property (POWER_OFF_PULSE |-> !(&$past(SUPPLY_OK)) && &$past(SUPPLY_OK, 2))
      else $error("off edge");
   a_off_delay: assert property (PWR_OFF_REQ |=> !MASTER_RESET_LEVEL[*3] ##[1:5] MASTER_RESET_LEVEL)
      else $error("off delay");
   a_tick_or: assert property (LINE_TICK_OUT == |$past(LINE_TICK))
      else $error("tick or");
   c_start: cover property ($fell(MASTER_RESET_LEVEL));
   c_fail: cover property (PWR_OFF_REQ);
   c_tick: cover property (LINE_TICK_OUT);
endmodule
bind pfail_top pfail_props #(.HOLD_CYCLES(HOLD_CYCLES), .DELAY_CYCLES(DELAY_CYCLES)) u_props (.*);

//--- tb/power_fail_interrupt_logic_test.sv
`timescale 1ns/10ps
module power_fail_interrupt_logic_test;
   logic clk = 0, rst = 1, oreq = 1, ak = 0, mrl, onp, offp, tko, onr, offr, any, pon, poff;
   logic [1:0] ok = 2'h3, tick = 2'h0, gate = 2'h3;
   logic [7:0] vec;
   int fails = 0, checks = 0, n;
   pfail_top #(.HOLD_CYCLES(20), .DELAY_CYCLES(5)) u_dut (.CLK(clk), .RST(rst), .CE(1'b1),
      .SUPPLY_OK(ok), .LINE_TICK(tick), .POWER_ON_GATE(gate), .OTHER_REQ(oreq),
      .OTHER_VEC(8'h3c), .MASTER_RESET_LEVEL(mrl), .POWER_ON_PULSE(onp), .POWER_OFF_PULSE(offp),
      .LINE_TICK_OUT(tko), .PWR_ON_REQ(onr), .PWR_OFF_REQ(offr), .IRQ_ANY(any), .IRQ_VEC(vec));
   pfail_cpu u_cpu (.clk(clk), .rst(rst), .on_req(onr), .off_req(offr), .ack_on(ak),
      .ack_off(1'b0), .pend_on(pon), .pend_off(poff));
   initial forever #5 clk = ~clk;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task step;
      @(posedge clk);
      #1;
   endtask
   task automatic wt(ref logic s);
      for (n = 1; s !== 1'b1; n++)
      begin
         step();
         if (n > 300)
         begin
            fails++;
            conclude();
         end
      end
   endtask
   task t_start;
      wt(onp);
      chk(n >= 20, 1'b1);
      chk({mrl, onr}, 2'h1);
      step();
      chk({vec, pon}, {8'h50, 1'b1});
      ak = 1'b1;
      step();
      ak = 1'b0;
      chk({vec, pon}, {8'h3c, 1'b0});
   endtask
   task t_fail;
      tick = 2'h2;
      ok = 2'h1;
      wt(offp);
      chk({offr, tko}, 2'h3);
      step();
      chk({vec, poff, pon}, {8'h51, 2'h2});
      wt(mrl);
      chk(n inside {[4:7]}, 1'b1);
   endtask
   task t_gate;
      ok = 2'h3;
      gate = 2'h1;
      repeat (40) step();
      chk({mrl, onp}, 2'h2);
      gate = 2'h3;
      wt(onp);
      chk(mrl, 1'b0);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      t_start();
      t_fail();
      t_gate();
      conclude();
   end
endmodule
